// file: rtl/rtc_flag_map.svh
// Register indices, field positions, reset values and timing counts.
`ifndef RTC_FLAG_MAP_SVH
`define RTC_FLAG_MAP_SVH

// Register indices; the byte address is four times the index.
`define RTC_IDX_RATE   6'h0A
`define RTC_IDX_ENABLE 6'h0B
`define RTC_IDX_FLAGS  6'h0C
`define RTC_IDX_BATT   6'h0D
`define RTC_IDX_ISTS   6'h10
`define RTC_IDX_IMASK  6'h11

// Event flag register and enable register bit positions.
`define RTC_BIT_IRQ_REQ  7
`define RTC_BIT_PERIODIC 6
`define RTC_BIT_ALARM    5
`define RTC_BIT_UPDATE   4

// Validity status register bit position.
`define RTC_BIT_VALID  7

// Interrupt status and mask bit positions.
`define RTC_IBIT_PERIODIC 0
`define RTC_IBIT_ALARM    1
`define RTC_IBIT_UPDATE   2

// Reset values.
`define RTC_RST_RATE   4'h0
`define RTC_RST_EVT    3'h0

// Periodic interval base, in clock cycles, shifted left by the rate.
`define RTC_PI_BASE_CYC 16

`endif

// file: rtl/rtc_flag_pkg.sv
// Types shared by the event flag and status register block.
package rtc_flag_pkg;

   // One bit per event source.
   typedef struct packed {
      logic periodic;
      logic alarm;
      logic update;
   } evt_t;

   // Classic Wishbone request from the master.
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } wb_req_t;

   // Classic Wishbone answer to the master.
   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_t;

endpackage

// file: rtl/periodic_timer.sv
// Periodic interval generator driven by the rate select field.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_flag_map.svh"

module periodic_timer #(
   parameter int BASE_CYC = `RTC_PI_BASE_CYC,
   parameter int CNT_W    = 24
) (
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Rate select, zero stops the timer.
   input  wire logic [3:0] rate_select_i,
   // One-cycle pulse per periodic interval.
   output logic            tick_o
);

   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [3:0]       rate_r;
   logic [3:0]       rate_nxt;
   logic             tick_r;
   logic             tick_nxt;
   logic [CNT_W-1:0] limit;

   ////////////////////////////////////////////////////////////////////////
   // A rate change restarts the interval.
   always_comb begin
      limit    = CNT_W'(BASE_CYC) << rate_select_i;
      rate_nxt = rate_select_i;
      tick_nxt = 1'b0;
      cnt_nxt  = cnt_r + CNT_W'(1);
      if (rate_select_i == 4'h0 || rate_select_i != rate_r) begin
         cnt_nxt = '0;
      end else if (cnt_r >= limit - CNT_W'(1)) begin
         cnt_nxt  = '0;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r  <= '0;
         rate_r <= `RTC_RST_RATE;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         rate_r <= rate_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;

   ////////////////////////////////////////////////////////////////////////
   a_tick_spaced: assert property (@(posedge clk_i) disable iff (rst_i)
      tick_r |=> !tick_r)
      else $error("Periodic ticks came back to back.");

endmodule
`default_nettype wire

// file: rtl/rtc_flag_status_regs.sv
// Event flag and battery validity status registers on classic Wishbone.
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_flag_map.svh"

// Function
// - The request flag is set while any event flag and its enable are 1.
// - A read of the event flag register clears the request and event flags.
// - The periodic flag is set once per interval picked by rate select.
// - Unused bits of the flag and validity registers always read as 0.
// - The validity bit reads 1 while the backup source is good, else 0.
module rtc_flag_status_regs #(
   parameter int PI_BASE_CYC = `RTC_PI_BASE_CYC,
   parameter int PI_CNT_W    = 24
) (
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Register bus.
   input  wire rtc_flag_pkg::wb_req_t wb_req_i,
   output var  rtc_flag_pkg::wb_rsp_t wb_rsp_o,
   // Event sources.
   input  wire logic                 alarm_match_i,
   input  wire logic                 update_end_i,
   input  wire logic                 battery_valid_i,
   // Interrupt.
   output logic                      irq_o
);
   import rtc_flag_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Declarations.
   logic       ack_r;
   wb_rsp_t    rsp_r;
   wb_rsp_t    rsp_nxt;
   logic [3:0] rate_r;
   logic [3:0] rate_nxt;
   evt_t       en_r;
   evt_t       en_nxt;
   evt_t       flags_r;
   evt_t       flags_nxt;
   logic       irq_request_flag_r;
   logic       irq_request_flag_nxt;
   evt_t       ists_r;
   evt_t       ists_nxt;
   evt_t       mask_r;
   evt_t       mask_nxt;
   logic       irq_r;
   logic       irq_nxt;
   logic       batt_r;
   logic       batt_nxt;
   logic       take;
   logic       wr;
   logic       rd_flags;
   logic [5:0] idx;
   logic [7:0] rdata;
   logic [2:0] w1c;
   evt_t       evt_set;
   logic       periodic_tick;

   ////////////////////////////////////////////////////////////////////////
   // Periodic interval source.
   periodic_timer #(
      .BASE_CYC (PI_BASE_CYC),
      .CNT_W    (PI_CNT_W)
   ) u_timer (
      .clk_i         (clk_i),
      .rst_i         (rst_i),
      .rate_select_i (rate_r),
      .tick_o        (periodic_tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus decode and event collection.
   always_comb begin
      take     = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
      idx      = wb_req_i.adr[7:2];
      wr       = take & wb_req_i.we & wb_req_i.sel[0];
      rd_flags = take & ~wb_req_i.we & (idx == `RTC_IDX_FLAGS);
      evt_set.periodic = periodic_tick;
      evt_set.alarm    = alarm_match_i;
      evt_set.update   = update_end_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers.
   always_comb begin
      rate_nxt = rate_r;
      en_nxt   = en_r;
      mask_nxt = mask_r;
      if (wr && idx == `RTC_IDX_RATE) begin
         rate_nxt = wb_req_i.dat[3:0];
      end
      if (wr && idx == `RTC_IDX_ENABLE) begin
         en_nxt.periodic = wb_req_i.dat[`RTC_BIT_PERIODIC];
         en_nxt.alarm    = wb_req_i.dat[`RTC_BIT_ALARM];
         en_nxt.update   = wb_req_i.dat[`RTC_BIT_UPDATE];
      end
      if (wr && idx == `RTC_IDX_IMASK) begin
         mask_nxt.periodic = wb_req_i.dat[`RTC_IBIT_PERIODIC];
         mask_nxt.alarm    = wb_req_i.dat[`RTC_IBIT_ALARM];
         mask_nxt.update   = wb_req_i.dat[`RTC_IBIT_UPDATE];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rate_r <= `RTC_RST_RATE;
         en_r   <= `RTC_RST_EVT;
         mask_r <= `RTC_RST_EVT;
      end else begin
         rate_r <= rate_nxt;
         en_r   <= en_nxt;
         mask_r <= mask_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Event flags, cleared by a read; a new event wins over the clear.
   always_comb begin
      flags_nxt = rd_flags ? evt_t'(3'h0) : flags_r;
      flags_nxt = flags_nxt | evt_set;
      irq_request_flag_nxt = rd_flags ? 1'b0 : irq_request_flag_r;
      irq_request_flag_nxt = irq_request_flag_nxt |
                             (|(flags_nxt & en_nxt));
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags_r            <= `RTC_RST_EVT;
         irq_request_flag_r <= 1'b0;
      end else begin
         flags_r            <= flags_nxt;
         irq_request_flag_r <= irq_request_flag_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, write one to clear, gated by the mask.
   always_comb begin
      w1c = 3'h0;
      if (wr && idx == `RTC_IDX_ISTS) begin
         w1c[2] = wb_req_i.dat[`RTC_IBIT_PERIODIC];
         w1c[1] = wb_req_i.dat[`RTC_IBIT_ALARM];
         w1c[0] = wb_req_i.dat[`RTC_IBIT_UPDATE];
      end
      ists_nxt = evt_t'(ists_r & ~w1c) | evt_set;
      irq_nxt  = |(ists_nxt & mask_nxt);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ists_r <= `RTC_RST_EVT;
         irq_r  <= 1'b0;
      end else begin
         ists_r <= ists_nxt;
         irq_r  <= irq_nxt;
      end
   end

   assign irq_o = irq_r;

   ////////////////////////////////////////////////////////////////////////
   // Read data and acknowledge, one cycle after the request.
   always_comb begin
      rdata    = 8'h00;
      batt_nxt = battery_valid_i;
      case (idx)
         `RTC_IDX_RATE: begin
            rdata[3:0] = rate_r;
         end
         `RTC_IDX_ENABLE: begin
            rdata[`RTC_BIT_PERIODIC] = en_r.periodic;
            rdata[`RTC_BIT_ALARM]    = en_r.alarm;
            rdata[`RTC_BIT_UPDATE]   = en_r.update;
         end
         `RTC_IDX_FLAGS: begin
            rdata[`RTC_BIT_IRQ_REQ]  = irq_request_flag_r;
            rdata[`RTC_BIT_PERIODIC] = flags_r.periodic;
            rdata[`RTC_BIT_ALARM]    = flags_r.alarm;
            rdata[`RTC_BIT_UPDATE]   = flags_r.update;
         end
         `RTC_IDX_BATT: begin
            rdata[`RTC_BIT_VALID] = batt_r;
         end
         `RTC_IDX_ISTS: begin
            rdata[`RTC_IBIT_PERIODIC] = ists_r.periodic;
            rdata[`RTC_IBIT_ALARM]    = ists_r.alarm;
            rdata[`RTC_IBIT_UPDATE]   = ists_r.update;
         end
         `RTC_IDX_IMASK: begin
            rdata[`RTC_IBIT_PERIODIC] = mask_r.periodic;
            rdata[`RTC_IBIT_ALARM]    = mask_r.alarm;
            rdata[`RTC_IBIT_UPDATE]   = mask_r.update;
         end
         default: begin
            rdata = 8'h00;
         end
      endcase
      rsp_nxt.ack = take;
      rsp_nxt.dat = '0;
      if (take && !wb_req_i.we) begin
         rsp_nxt.dat[7:0] = rdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsp_r  <= '0;
         batt_r <= 1'b0;
      end else begin
         rsp_r  <= rsp_nxt;
         batt_r <= batt_nxt;
      end
   end

   assign ack_r    = rsp_r.ack;
   assign wb_rsp_o = rsp_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic rd_flags_ack;
   logic rd_batt_ack;
   assign rd_flags_ack = rsp_r.ack & ~wb_req_i.we &
                         (idx == `RTC_IDX_FLAGS);
   assign rd_batt_ack  = rsp_r.ack & ~wb_req_i.we &
                         (idx == `RTC_IDX_BATT);

   a_irq_flag_set: assert property (
      |(flags_r & en_r) |-> irq_request_flag_r)
      else $error("Enabled event flag without request flag.");

   a_flag_rise_cause: assert property (
      $rose(irq_request_flag_r) |-> |(flags_r & en_r))
      else $error("Request flag rose without an enabled event flag.");

   a_read_clears: assert property (
      rd_flags && evt_set == 3'h0 |=> flags_r == 3'h0 && !irq_request_flag_r)
      else $error("Flag register read did not clear the flags.");

   a_read_returns_old: assert property (
      rd_flags |=>
         rsp_r.dat[`RTC_BIT_IRQ_REQ] == $past(irq_request_flag_r) &&
         rsp_r.dat[`RTC_BIT_PERIODIC] == $past(flags_r.periodic) &&
         rsp_r.dat[`RTC_BIT_ALARM] == $past(flags_r.alarm) &&
         rsp_r.dat[`RTC_BIT_UPDATE] == $past(flags_r.update))
      else $error("Flag register read did not return the flags it cleared.");

   a_periodic_set: assert property (
      periodic_tick |=> flags_r.periodic && ists_r.periodic)
      else $error("Periodic tick did not set its flag.");

   a_periodic_cause: assert property (
      $rose(flags_r.periodic) |-> $past(periodic_tick))
      else $error("Periodic flag rose without a periodic tick.");

   a_rate_zero_quiet: assert property (
      rate_r == 4'h0 && $past(rate_r) == 4'h0 |-> !periodic_tick)
      else $error("Periodic tick while the rate select is zero.");

   a_flags_unused: assert property (
      rd_flags_ack |-> rsp_r.dat[3:0] == 4'h0 && rsp_r.dat[31:8] == '0)
      else $error("Unused flag register bits read nonzero.");

   a_batt_unused: assert property (
      rd_batt_ack |-> rsp_r.dat[6:0] == 7'h00 && rsp_r.dat[31:8] == '0)
      else $error("Unused validity register bits read nonzero.");

   a_batt_value: assert property (
      rd_batt_ack |-> rsp_r.dat[`RTC_BIT_VALID] == $past(batt_r))
      else $error("Validity bit does not follow the backup source.");

   a_alarm_set: assert property (
      alarm_match_i |=> flags_r.alarm ##0 ists_r.alarm)
      else $error("Alarm match did not set the alarm flag.");

   a_update_set: assert property (
      update_end_i |=> flags_r.update)
      else $error("Update end did not set the update flag.");

   a_flag_sticky: assert property (
      flags_r.alarm && !rd_flags |=> flags_r.alarm)
      else $error("Alarm flag dropped without a read.");

   a_alarm_cause: assert property (
      $rose(flags_r.alarm) |-> $past(alarm_match_i))
      else $error("Alarm flag rose without an alarm match.");

   a_update_cause: assert property (
      $rose(flags_r.update) |-> $past(update_end_i))
      else $error("Update flag rose without an update end.");

   a_ack_pulse: assert property (
      wb_req_i.cyc && wb_req_i.stb && !rsp_r.ack |=>
         rsp_r.ack ##1 !rsp_r.ack)
      else $error("Acknowledge is not a single cycle after the request.");

   a_irq_output: assert property (
      irq_o == |(ists_r & mask_r))
      else $error("Interrupt output disagrees with masked status.");

   c_read_set_flags: cover property (rd_flags_ack &&
                                     rsp_r.dat[`RTC_BIT_IRQ_REQ]);
   c_batt_good: cover property (rd_batt_ack && rsp_r.dat[`RTC_BIT_VALID]);
   c_irq_rise: cover property (!irq_o ##1 irq_o);
   c_tick_read: cover property (periodic_tick ##[1:64] rd_flags);
   c_clear_race: cover property (rd_flags && evt_set != 3'h0);

endmodule
`default_nettype wire

// file: testbench/rtc_flag_status_regs_bench.sv
// Self-checking bench for the event flag and validity status registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_flag_map.svh"

module rtc_flag_status_regs_bench;
   import rtc_flag_pkg::*;

   logic    clk_i;
   logic    rst_i;
   wb_req_t req;
   wb_rsp_t rsp;
   logic    alarm_match_i;
   logic    update_end_i;
   logic    battery_valid_i;
   logic    irq_o;
   int      fails;
   int      total_checks;
   logic [31:0] rd_val;

   ////////////////////////////////////////////////////////////////////////
   rtc_flag_status_regs #(
      .PI_BASE_CYC (2),
      .PI_CNT_W    (24)
   ) dut (
      .clk_i           (clk_i),
      .rst_i           (rst_i),
      .wb_req_i        (req),
      .wb_rsp_o        (rsp),
      .alarm_match_i   (alarm_match_i),
      .update_end_i    (update_end_i),
      .battery_valid_i (battery_valid_i),
      .irq_o           (irq_o)
   );

   always #12.5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", name, exp, got);
         fails++;
      end
   endtask

   // One classic Wishbone cycle; waits for ack and takes data at that edge.
   task automatic wb_cycle(input logic we, input logic [5:0] idx,
                           input logic [7:0] wdat, input logic [3:0] sel,
                           output logic [31:0] rdat);
      int n;
      n = 0;
      @(posedge clk_i);
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: sel,
               dat: {24'h00_0000, wdat}};
      do begin
         @(posedge clk_i);
         n++;
      end while (rsp.ack !== 1'b1 && n < 50);
      if (n >= 50) begin
         $display("[ERR] ack wait expected 1 seen %b", rsp.ack);
         fails++;
      end
      rdat = rsp.dat;
      req <= '0;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      wb_cycle(1'b1, idx, d, 4'h1, rd_val);
   endtask

   task automatic rd(input string name, input logic [5:0] idx,
                     input logic [7:0] exp);
      wb_cycle(1'b0, idx, 8'h00, 4'hF, rd_val);
      chk(name, {24'h00_0000, exp}, rd_val);
   endtask

   task automatic pulse(input bit alarm);
      @(posedge clk_i);
      if (alarm) alarm_match_i <= 1'b1;
      else update_end_i <= 1'b1;
      @(posedge clk_i);
      alarm_match_i <= 1'b0;
      update_end_i  <= 1'b0;
   endtask

   task automatic chk_irq(input logic exp);
      @(posedge clk_i);
      #1;
      chk("irq_o", {31'h0000_0000, exp}, {31'h0000_0000, irq_o});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(25 * 6000);
      fails++;
      end_of_test();
   end

   initial begin
      clk_i = 1'b0;
      rst_i = 1'b1;
      req = '0;
      alarm_match_i = 1'b0;
      update_end_i = 1'b0;
      battery_valid_i = 1'b0;
      fails = 0;
      total_checks = 0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // Reset state and unused bits.
      rd("flags", `RTC_IDX_FLAGS, 8'h00);
      rd("valid", `RTC_IDX_BATT, 8'h00);
      battery_valid_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd("valid", `RTC_IDX_BATT, 8'h80);
      battery_valid_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd("valid", `RTC_IDX_BATT, 8'h00);
      // Alarm with its enable set, then clear on read.
      wr(`RTC_IDX_ENABLE, 8'h20);
      pulse(1'b1);
      rd("flags", `RTC_IDX_FLAGS, 8'hA0);
      rd("flags", `RTC_IDX_FLAGS, 8'h00);
      // Update without its enable: no request flag.
      pulse(1'b0);
      rd("flags", `RTC_IDX_FLAGS, 8'h10);
      rd("flags", `RTC_IDX_FLAGS, 8'h00);
      // Refused writes: low byte not selected, unmapped index.
      wb_cycle(1'b1, `RTC_IDX_ENABLE, 8'h70, 4'hE, rd_val);
      rd("enable", `RTC_IDX_ENABLE, 8'h20);
      wr(6'h3F, 8'hFF);
      rd("unmapped", 6'h3F, 8'h00);
      // Periodic source at rate 4: interval of 32 cycles.
      wr(`RTC_IDX_ENABLE, 8'h40);
      wr(`RTC_IDX_RATE, 8'h04);
      rd("flags", `RTC_IDX_FLAGS, 8'h00);
      rd("rate", `RTC_IDX_RATE, 8'h04);
      repeat (40) @(posedge clk_i);
      rd("flags", `RTC_IDX_FLAGS, 8'hC0);
      wr(`RTC_IDX_RATE, 8'h00);
      wb_cycle(1'b0, `RTC_IDX_FLAGS, 8'h00, 4'hF, rd_val);
      repeat (40) @(posedge clk_i);
      rd("flags", `RTC_IDX_FLAGS, 8'h00);
      // Interrupt status, mask and level output.
      wr(`RTC_IDX_ISTS, 8'h07);
      wr(`RTC_IDX_IMASK, 8'h02);
      rd("mask", `RTC_IDX_IMASK, 8'h02);
      chk_irq(1'b0);
      pulse(1'b1);
      #1;
      chk("irq_o", 32'h0000_0001, {31'h0000_0000, irq_o});
      rd("status", `RTC_IDX_ISTS, 8'h02);
      rd("flags", `RTC_IDX_FLAGS, 8'h20);
      wr(`RTC_IDX_IMASK, 8'h00);
      chk_irq(1'b0);
      wr(`RTC_IDX_IMASK, 8'h02);
      chk_irq(1'b1);
      wr(`RTC_IDX_ISTS, 8'h02);
      chk_irq(1'b0);
      rd("status", `RTC_IDX_ISTS, 8'h00);
      pulse(1'b0);
      chk_irq(1'b0);
      rd("status", `RTC_IDX_ISTS, 8'h04);
      end_of_test();
   end

endmodule
`default_nettype wire
